// ===== hw/tmr_defines.svh
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// Register addresses on the special-function register bus.
`define TMR_ADDR_CTRL    8'h88
`define TMR_ADDR_MODE    8'h89
`define TMR_ADDR_T0_LO   8'h8A
`define TMR_ADDR_T1_LO   8'h8B
`define TMR_ADDR_T0_HI   8'h8C
`define TMR_ADDR_T1_HI   8'h8D
`define TMR_ADDR_CKDIV   8'h8E

// Reset values.
`define TMR_RST_CTRL     8'h00
`define TMR_RST_MODE     8'h00
`define TMR_RST_BYTE     8'h00
`define TMR_RST_CKDIV    8'h01

// Bit positions in the mode register.
`define TMR_MODE_T1_GATE 7
`define TMR_MODE_T1_SRC  6
`define TMR_MODE_T1_HI   5
`define TMR_MODE_T1_LO   4
`define TMR_MODE_T0_GATE 3
`define TMR_MODE_T0_SRC  2
`define TMR_MODE_T0_HI   1
`define TMR_MODE_T0_LO   0

// Bit positions in the control register.
`define TMR_CTRL_TF1     7
`define TMR_CTRL_TR1     6
`define TMR_CTRL_TF0     5
`define TMR_CTRL_TR0     4

// Prescale select bits in the clock divide register.
`define TMR_CKDIV_T1     4
`define TMR_CKDIV_T0     3

// Processor clock divide ratios for timer use.
`define TMR_DIV_FAST     4
`define TMR_DIV_SLOW     12

// Top value of the five-bit part of the low byte in 13-bit mode.
`define TMR_LO13_MAX     5'h1F

`endif

// ===== hw/tmr_edge.sv
`include "tmr_defines.svh"
`default_nettype none
module tmr_edge (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      fall_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Two-stage synchroniser; logic looks only at sync_r and its one-cycle-delayed copy last_r.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // A high-to-low step of the synchronised level is one event.
  assign level_o = sync_r;
  assign fall_o  = last_r & ~sync_r;

endmodule
`default_nettype wire

// ===== hw/tmr_pkg.sv
`default_nettype none
package tmr_pkg;

  // Two-bit mode-select code of one timer.
  typedef enum logic [1:0] {
    TMR_MODE_13    = 2'h0,
    TMR_MODE_16    = 2'h1,
    TMR_MODE_RELD  = 2'h2,
    TMR_MODE_SPLIT = 2'h3
  } tmr_mode_type;

endpackage
`default_nettype wire

// ===== hw/tmr_top.sv
`include "tmr_defines.svh"
`default_nettype none
// Functional notes
// - Two timers, tick or external pin counting; only the timer 2 pin edge is passed out.
// - Count pins are port0 bit5, bit6, port1 bit0.
// - Sixteen-bit count as low and high bytes.
// - Code 00 is 13-bit, 01 is 16-bit.
// - Code 10 is 8-bit with auto-reload.
// - Code 11 splits timer 0 only.
// - Timer 1 gate needs run bit and pin high.
// - Timer 0 gate needs run bit and pin high.
// - Timer 1 source: clock/4 or /12, or pin.
// - Timer 0 source: clock/4 or /12, or pin.
// - Mode register upper nibble controls timer 1.
// - Mode register lower nibble controls timer 0.
// - Overflow flag sets; vector acknowledge clears it.
// - Run bit in control register enables counting.
module tmr_top #(
  parameter int FAST_DIV = `TMR_DIV_FAST,
  parameter int SLOW_DIV = `TMR_DIV_SLOW
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            sfr_sel_o,
  input  wire logic [7:0] port0_pins_i,
  input  wire logic [3:0] port1_pins_i,
  input  wire logic       ext_irq0_pin_n_i,
  input  wire logic       ext_irq1_pin_n_i,
  input  wire logic       timer0_vector_ack_i,
  input  wire logic       timer1_vector_ack_i,
  output logic            timer0_overflow_flag_o,
  output logic            timer1_overflow_flag_o,
  output logic            timer2_count_pulse_o
);

  localparam int FW = $clog2(FAST_DIV);
  localparam int SW = $clog2(SLOW_DIV);

  // The divider counters need at least two states each.
  if (FAST_DIV < 2 || SLOW_DIV < 2) begin : g_bad_div
    $error("tmr_top: divide ratios must be at least 2");
  end

  // Register state.
  logic [7:0]    timer_mode_reg_r;
  logic [7:0]    timer_mode_reg_nxt;
  logic [7:0]    clock_divide_reg_r;
  logic [7:0]    clock_divide_reg_nxt;
  logic [3:0]    ctrl_low_r;
  logic [3:0]    ctrl_low_nxt;
  logic          timer0_run_r;
  logic          timer0_run_nxt;
  logic          timer1_run_r;
  logic          timer1_run_nxt;
  logic          timer0_overflow_flag_r;
  logic          timer0_overflow_flag_nxt;
  logic          timer1_overflow_flag_r;
  logic          timer1_overflow_flag_nxt;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;
  logic [FW-1:0] fast_cnt_r;
  logic [FW-1:0] fast_cnt_nxt;
  logic [SW-1:0] slow_cnt_r;
  logic [SW-1:0] slow_cnt_nxt;

  // Decoded accesses.
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_ckdiv;
  logic       wr_t0_lo;
  logic       wr_t0_hi;
  logic       wr_t1_lo;
  logic       wr_t1_hi;
  logic [7:0] rd_mux;

  // Synchronised pins.
  logic cnt0_fall;
  logic cnt1_fall;
  logic irq0_level;
  logic irq1_level;

  // Counting controls.
  logic tick_fast;
  logic tick_slow;
  logic t0_clk_tick;
  logic t1_clk_tick;
  logic t0_src;
  logic t1_src;
  logic t0_enable;
  logic t1_enable;
  logic t0_inc;
  logic t1_inc;
  logic t0_hi_inc;
  logic t0_split;

  // Count values and overflow events.
  logic [7:0] t0_lo;
  logic [7:0] t0_hi;
  logic [7:0] t1_lo;
  logic [7:0] t1_hi;
  logic       t0_ovf;
  logic       t0_hi_ovf;
  logic       t1_ovf;
  logic       t0_set;
  logic       t1_set;

  tmr_pkg::tmr_mode_type t0_mode;
  tmr_pkg::tmr_mode_type t1_mode;

  // External count and gate pins all cross from outside the clock domain.
  tmr_edge u_cnt0 (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (port0_pins_i[5]),
    .level_o (),
    .fall_o  (cnt0_fall)
  );

  tmr_edge u_cnt1 (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (port0_pins_i[6]),
    .level_o (),
    .fall_o  (cnt1_fall)
  );

  // Timer 2 itself lives elsewhere; only its counted edge is offered here.
  tmr_edge u_cnt2 (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (port1_pins_i[0]),
    .level_o (),
    .fall_o  (timer2_count_pulse_o)
  );

  tmr_edge u_irq0 (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (ext_irq0_pin_n_i),
    .level_o (irq0_level),
    .fall_o  ()
  );

  tmr_edge u_irq1 (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (ext_irq1_pin_n_i),
    .level_o (irq1_level),
    .fall_o  ()
  );

  // Address decode; unmapped addresses are ignored and read as zero.
  always_comb begin
    wr_ctrl   = sfr_wr_i && sfr_addr_i == `TMR_ADDR_CTRL;
    wr_mode   = sfr_wr_i && sfr_addr_i == `TMR_ADDR_MODE;
    wr_ckdiv  = sfr_wr_i && sfr_addr_i == `TMR_ADDR_CKDIV;
    wr_t0_lo  = sfr_wr_i && sfr_addr_i == `TMR_ADDR_T0_LO;
    wr_t0_hi  = sfr_wr_i && sfr_addr_i == `TMR_ADDR_T0_HI;
    wr_t1_lo  = sfr_wr_i && sfr_addr_i == `TMR_ADDR_T1_LO;
    wr_t1_hi  = sfr_wr_i && sfr_addr_i == `TMR_ADDR_T1_HI;
    sfr_sel_o = 1'b1;
    unique case (sfr_addr_i)
      `TMR_ADDR_CTRL: rd_mux = {timer1_overflow_flag_r, timer1_run_r,
                                timer0_overflow_flag_r, timer0_run_r, ctrl_low_r};
      `TMR_ADDR_MODE:  rd_mux = timer_mode_reg_r;
      `TMR_ADDR_CKDIV: rd_mux = clock_divide_reg_r;
      `TMR_ADDR_T0_LO: rd_mux = t0_lo;
      `TMR_ADDR_T0_HI: rd_mux = t0_hi;
      `TMR_ADDR_T1_LO: rd_mux = t1_lo;
      `TMR_ADDR_T1_HI: rd_mux = t1_hi;
      default: begin
        rd_mux    = 8'h00;
        sfr_sel_o = 1'b0;
      end
    endcase
  end

  // Free-running prescalers; one tick each per divide period.
  always_comb begin
    tick_fast    = (fast_cnt_r == FW'(FAST_DIV - 1));
    tick_slow    = (slow_cnt_r == SW'(SLOW_DIV - 1));
    fast_cnt_nxt = tick_fast ? '0 : fast_cnt_r + FW'(1);
    slow_cnt_nxt = tick_slow ? '0 : slow_cnt_r + SW'(1);
  end

  // Source, gate and run selection for both timers.
  always_comb begin
    t0_mode = tmr_pkg::tmr_mode_type'(timer_mode_reg_r[`TMR_MODE_T0_HI:`TMR_MODE_T0_LO]);
    t1_mode = tmr_pkg::tmr_mode_type'(timer_mode_reg_r[`TMR_MODE_T1_HI:`TMR_MODE_T1_LO]);
    t0_split = (t0_mode == tmr_pkg::TMR_MODE_SPLIT);
    t0_clk_tick = clock_divide_reg_r[`TMR_CKDIV_T0] ? tick_fast : tick_slow;
    t1_clk_tick = clock_divide_reg_r[`TMR_CKDIV_T1] ? tick_fast : tick_slow;
    t0_src = timer_mode_reg_r[`TMR_MODE_T0_SRC] ? cnt0_fall : t0_clk_tick;
    t1_src = timer_mode_reg_r[`TMR_MODE_T1_SRC] ? cnt1_fall : t1_clk_tick;
    t0_enable = timer0_run_r && (!timer_mode_reg_r[`TMR_MODE_T0_GATE] || irq0_level);
    t1_enable = timer1_run_r && (!timer_mode_reg_r[`TMR_MODE_T1_GATE] || irq1_level);
    t0_inc    = t0_enable && t0_src;
    t1_inc    = t1_enable && t1_src;
    // In split mode the upper half of timer 0 borrows timer 1's run bit.
    t0_hi_inc = t0_split && timer1_run_r && t0_clk_tick;
  end

  tmr_unit #(
    .SPLIT_OK (1'b1)
  ) u_t0 (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .mode_i   (t0_mode),
    .inc_i    (t0_inc),
    .inc_hi_i (t0_hi_inc),
    .wr_lo_i  (wr_t0_lo),
    .wr_hi_i  (wr_t0_hi),
    .wdata_i  (sfr_wdata_i),
    .lo_o     (t0_lo),
    .hi_o     (t0_hi),
    .ovf_o    (t0_ovf),
    .ovf_hi_o (t0_hi_ovf)
  );

  // Timer 1 has no split option and holds its count under code 11.
  tmr_unit #(
    .SPLIT_OK (1'b0)
  ) u_t1 (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .mode_i   (t1_mode),
    .inc_i    (t1_inc),
    .inc_hi_i (1'b0),
    .wr_lo_i  (wr_t1_lo),
    .wr_hi_i  (wr_t1_hi),
    .wdata_i  (sfr_wdata_i),
    .lo_o     (t1_lo),
    .hi_o     (t1_hi),
    .ovf_o    (t1_ovf),
    .ovf_hi_o ()
  );

  // Flags: a hardware set beats a vector acknowledge or a software write.
  always_comb begin
    t0_set = t0_ovf;
    t1_set = t0_split ? t0_hi_ovf : t1_ovf;
    timer_mode_reg_nxt   = wr_mode ? sfr_wdata_i : timer_mode_reg_r;
    clock_divide_reg_nxt = wr_ckdiv ? sfr_wdata_i : clock_divide_reg_r;
    ctrl_low_nxt   = wr_ctrl ? sfr_wdata_i[3:0] : ctrl_low_r;
    timer0_run_nxt = wr_ctrl ? sfr_wdata_i[`TMR_CTRL_TR0] : timer0_run_r;
    timer1_run_nxt = wr_ctrl ? sfr_wdata_i[`TMR_CTRL_TR1] : timer1_run_r;
    timer0_overflow_flag_nxt = wr_ctrl ? sfr_wdata_i[`TMR_CTRL_TF0]
                             : timer0_overflow_flag_r && !timer0_vector_ack_i;
    timer1_overflow_flag_nxt = wr_ctrl ? sfr_wdata_i[`TMR_CTRL_TF1]
                             : timer1_overflow_flag_r && !timer1_vector_ack_i;
    if (t0_set) begin
      timer0_overflow_flag_nxt = 1'b1;
    end
    if (t1_set) begin
      timer1_overflow_flag_nxt = 1'b1;
    end
    rdata_nxt = sfr_rd_i ? rd_mux : rdata_r;
  end

  // All register state.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timer_mode_reg_r       <= `TMR_RST_MODE;
      clock_divide_reg_r     <= `TMR_RST_CKDIV;
      ctrl_low_r             <= 4'h0;
      timer0_run_r           <= 1'b0;
      timer1_run_r           <= 1'b0;
      timer0_overflow_flag_r <= 1'b0;
      timer1_overflow_flag_r <= 1'b0;
      rdata_r                <= 8'h00;
      fast_cnt_r             <= '0;
      slow_cnt_r             <= '0;
    end else begin
      timer_mode_reg_r       <= timer_mode_reg_nxt;
      clock_divide_reg_r     <= clock_divide_reg_nxt;
      ctrl_low_r             <= ctrl_low_nxt;
      timer0_run_r           <= timer0_run_nxt;
      timer1_run_r           <= timer1_run_nxt;
      timer0_overflow_flag_r <= timer0_overflow_flag_nxt;
      timer1_overflow_flag_r <= timer1_overflow_flag_nxt;
      rdata_r                <= rdata_nxt;
      fast_cnt_r             <= fast_cnt_nxt;
      slow_cnt_r             <= slow_cnt_nxt;
    end
  end

  assign sfr_rdata_o            = rdata_r;
  assign timer0_overflow_flag_o = timer0_overflow_flag_r;
  assign timer1_overflow_flag_o = timer1_overflow_flag_r;

  flag_set_wins_a: assert property (@(posedge clock_i) disable iff (rst_i)
    t0_set |=> timer0_overflow_flag_r)
    else $error("timer 0 overflow did not set its flag");

  ack_clears_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (timer1_vector_ack_i && !t1_set && !wr_ctrl) |=> !timer1_overflow_flag_r)
    else $error("vector acknowledge did not clear timer 1 flag");

  stopped_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (!timer0_run_r && !wr_t0_lo && !wr_t0_hi && !t0_split) |=> $stable(t0_lo))
    else $error("timer 0 counted while its run bit was clear");

  gate0_block_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (timer_mode_reg_r[`TMR_MODE_T0_GATE] && !irq0_level) |-> !t0_inc)
    else $error("timer 0 advanced with gate set and pin low");

  gate1_block_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (timer_mode_reg_r[`TMR_MODE_T1_GATE] && !irq1_level) |-> !t1_inc)
    else $error("timer 1 advanced with gate set and pin low");

  slow_period_a: assert property (@(posedge clock_i) disable iff (rst_i)
    tick_slow |=> !tick_slow [*8] ##1 !tick_slow [*3] ##1 tick_slow)
    else $error("slow prescale tick is not one in twelve clocks");

  fast_period_a: assert property (@(posedge clock_i) disable iff (rst_i)
    tick_fast |=> !tick_fast [*3] ##1 tick_fast)
    else $error("fast prescale tick is not one in four clocks");

  pin_count_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (timer_mode_reg_r[`TMR_MODE_T1_SRC] && t1_enable) |-> (t1_inc == cnt1_fall))
    else $error("timer 1 counter use did not follow pin falling edges");

  t1_split_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (t1_mode == tmr_pkg::TMR_MODE_SPLIT && !wr_t1_lo && !wr_t1_hi)
    |=> ($stable(t1_lo) && $stable(t1_hi)))
    else $error("timer 1 counted under split code");

  mode16_step_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (t0_mode == tmr_pkg::TMR_MODE_16 && t0_inc && !wr_t0_lo && !wr_t0_hi && !wr_mode)
    |=> {t0_hi, t0_lo} == {$past(t0_hi), $past(t0_lo)} + 16'h0001)
    else $error("16-bit mode did not advance by one");

  byte_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_t1_hi |=> (t1_hi == $past(sfr_wdata_i)))
    else $error("high byte write did not land");

endmodule
`default_nettype wire

// ===== hw/tmr_unit.sv
`include "tmr_defines.svh"
`default_nettype none
module tmr_unit #(
  parameter bit SPLIT_OK = 1'b1
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire tmr_pkg::tmr_mode_type mode_i,
  input  wire logic                 inc_i,
  input  wire logic                 inc_hi_i,
  input  wire logic                 wr_lo_i,
  input  wire logic                 wr_hi_i,
  input  wire logic [7:0]           wdata_i,
  output logic [7:0]                lo_o,
  output logic [7:0]                hi_o,
  output logic                      ovf_o,
  output logic                      ovf_hi_o
);

  logic [7:0] lo_r;
  logic [7:0] lo_nxt;
  logic [7:0] hi_r;
  logic [7:0] hi_nxt;

  // Count step per mode; a software write to a byte wins over counting.
  always_comb begin
    lo_nxt   = lo_r;
    hi_nxt   = hi_r;
    ovf_o    = 1'b0;
    ovf_hi_o = 1'b0;
    unique case (mode_i)
      tmr_pkg::TMR_MODE_13: begin
        if (inc_i) begin
          lo_nxt[4:0] = lo_r[4:0] + 5'h01;
          if (lo_r[4:0] == `TMR_LO13_MAX) begin
            hi_nxt = hi_r + 8'h01;
            ovf_o  = (hi_r == 8'hFF);
          end
        end
      end
      tmr_pkg::TMR_MODE_16: begin
        if (inc_i) begin
          {hi_nxt, lo_nxt} = {hi_r, lo_r} + 16'h0001;
          ovf_o = ({hi_r, lo_r} == 16'hFFFF);
        end
      end
      tmr_pkg::TMR_MODE_RELD: begin
        if (inc_i) begin
          lo_nxt = (lo_r == 8'hFF) ? hi_r : lo_r + 8'h01;
          ovf_o  = (lo_r == 8'hFF);
        end
      end
      tmr_pkg::TMR_MODE_SPLIT: begin
        // Without the split option the timer simply holds its count.
        if (SPLIT_OK && inc_i) begin
          lo_nxt = lo_r + 8'h01;
          ovf_o  = (lo_r == 8'hFF);
        end
        if (SPLIT_OK && inc_hi_i) begin
          hi_nxt   = hi_r + 8'h01;
          ovf_hi_o = (hi_r == 8'hFF);
        end
      end
    endcase
    if (wr_lo_i) begin
      lo_nxt = wdata_i;
    end
    if (wr_hi_i) begin
      hi_nxt = wdata_i;
    end
  end

  // Count storage.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lo_r <= `TMR_RST_BYTE;
      hi_r <= `TMR_RST_BYTE;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
    end
  end

  assign lo_o = lo_r;
  assign hi_o = hi_r;

  reload_value_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode_i == tmr_pkg::TMR_MODE_RELD && inc_i && lo_r == 8'hFF && !wr_lo_i && !wr_hi_i)
    |=> (lo_r == hi_r && hi_r == $past(hi_r)))
    else $error("auto-reload did not load low byte from high byte");

  wrap13_flag_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (mode_i == tmr_pkg::TMR_MODE_13 && inc_i && !wr_lo_i && !wr_hi_i
     && hi_r == 8'hFF && lo_r[4:0] == `TMR_LO13_MAX)
    |-> ovf_o ##1 (hi_r == 8'h00 && lo_r[4:0] == 5'h00))
    else $error("13-bit wrap did not flag overflow or clear count");

endmodule
`default_nettype wire

// ===== sim/testbench.sv
`include "tmr_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock_i;
  logic       rst_i;
  logic [7:0] sfr_addr_i;
  logic [7:0] sfr_wdata_i;
  logic       sfr_wr_i;
  logic       sfr_rd_i;
  logic [7:0] sfr_rdata_o;
  logic       sfr_sel_o;
  logic [7:0] port0;
  logic [3:0] port1;
  logic       irq0_n;
  logic       irq1_n;
  logic       ack0;
  logic       ack1;
  logic       flag0;
  logic       flag1;
  logic       t2_pulse;
  logic [7:0] v;
  int         errors;
  int         total_checks;
  int         t2_count;

  // One comparison; an unknown never counts as a match.
  `define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

  tmr_top #(
    .FAST_DIV(`TMR_DIV_FAST),
    .SLOW_DIV(`TMR_DIV_SLOW)
  ) u_tmr_top (
    .clock_i               (clock_i),
    .rst_i                 (rst_i),
    .sfr_addr_i            (sfr_addr_i),
    .sfr_wdata_i           (sfr_wdata_i),
    .sfr_wr_i              (sfr_wr_i),
    .sfr_rd_i              (sfr_rd_i),
    .sfr_rdata_o           (sfr_rdata_o),
    .sfr_sel_o             (sfr_sel_o),
    .port0_pins_i          (port0),
    .port1_pins_i          (port1),
    .ext_irq0_pin_n_i      (irq0_n),
    .ext_irq1_pin_n_i      (irq1_n),
    .timer0_vector_ack_i   (ack0),
    .timer1_vector_ack_i   (ack1),
    .timer0_overflow_flag_o(flag0),
    .timer1_overflow_flag_o(flag1),
    .timer2_count_pulse_o  (t2_pulse)
  );

  tmr_pins u_tmr_pins (
    .clock_i (clock_i),
    .port0_o (port0),
    .port1_o (port1),
    .irq0_n_o(irq0_n),
    .irq1_n_o(irq1_n)
  );

  // The pulse is one cycle wide, so it is counted at every rising edge.
  always @(posedge clock_i) begin
    if (t2_pulse === 1'b1) t2_count++;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    @(negedge clock_i);
    sfr_wr_i = 1'b0;
  endtask

  // Read data is registered at the read edge, so it is settled by the next falling edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    sfr_addr_i = a;
    sfr_rd_i   = 1'b1;
    @(negedge clock_i);
    sfr_rd_i = 1'b0;
    d        = sfr_rdata_o;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_reset();
    rd(`TMR_ADDR_CTRL, v);
    `CHK(v, 8'h00)
    rd(`TMR_ADDR_T0_LO, v);
    `CHK(v, 8'h00)
    rd(`TMR_ADDR_CKDIV, v);
    `CHK(v, 8'h01)
    wr(`TMR_ADDR_MODE, 8'hA5);
    rd(`TMR_ADDR_MODE, v);
    `CHK(v, 8'hA5)
    `CHK(sfr_sel_o, 1'b1)
    rd(8'h8F, v);
    `CHK(v, 8'h00)
    `CHK(sfr_sel_o, 1'b0)
    $display("test reset done");
  endtask

  // Counter use, full 16 bits: the carry out of the low byte reaches the high byte.
  task automatic t_count16();
    wr(`TMR_ADDR_MODE, 8'h05);
    wr(`TMR_ADDR_T0_LO, 8'hFE);
    wr(`TMR_ADDR_T0_HI, 8'h12);
    wr(`TMR_ADDR_CTRL, 8'h10);
    u_tmr_pins.pulse(0, 5, 3);
    rd(`TMR_ADDR_T0_LO, v);
    `CHK(v, 8'h01)
    rd(`TMR_ADDR_T0_HI, v);
    `CHK(v, 8'h13)
    $display("test count16 done");
  endtask

  // The 13-bit count wraps from all ones, then a vector acknowledge clears the flag.
  task automatic t_count13();
    wr(`TMR_ADDR_MODE, 8'h04);
    wr(`TMR_ADDR_T0_HI, 8'hFF);
    wr(`TMR_ADDR_T0_LO, 8'h1F);
    wr(`TMR_ADDR_CTRL, 8'h10);
    u_tmr_pins.pulse(0, 5, 1);
    rd(`TMR_ADDR_T0_LO, v);
    `CHK(v, 8'h00)
    rd(`TMR_ADDR_T0_HI, v);
    `CHK(v, 8'h00)
    `CHK(flag0, 1'b1)
    @(negedge clock_i);
    ack0 = 1'b1;
    @(negedge clock_i);
    ack0 = 1'b0;
    `CHK(flag0, 1'b0)
    $display("test count13 done");
  endtask

  task automatic t_reload();
    wr(`TMR_ADDR_MODE, 8'h06);
    wr(`TMR_ADDR_T0_HI, 8'h80);
    wr(`TMR_ADDR_T0_LO, 8'hFE);
    wr(`TMR_ADDR_CTRL, 8'h10);
    u_tmr_pins.pulse(0, 5, 2);
    rd(`TMR_ADDR_T0_LO, v);
    `CHK(v, 8'h80)
    rd(`TMR_ADDR_T0_HI, v);
    `CHK(v, 8'h80)
    `CHK(flag0, 1'b1)
    $display("test reload done");
  endtask

  // Both timers: the run bit alone, then the gate pin low and high.
  task automatic t_gate();
    logic [7:0] lo;
    for (int tm = 0; tm < 2; tm++) begin
      lo = (tm == 0) ? `TMR_ADDR_T0_LO : `TMR_ADDR_T1_LO;
      wr(`TMR_ADDR_MODE, 8'h0D << (4 * tm));
      wr(`TMR_ADDR_CTRL, 8'h00);
      wr(lo, 8'h00);
      u_tmr_pins.pulse(0, 5 + tm, 2);
      rd(lo, v);
      `CHK(v, 8'h00)
      wr(`TMR_ADDR_CTRL, 8'h10 << (2 * tm));
      u_tmr_pins.gate(1'b0, 1'b0);
      u_tmr_pins.pulse(0, 5 + tm, 2);
      rd(lo, v);
      `CHK(v, 8'h00)
      u_tmr_pins.gate(1'b1, 1'b1);
      u_tmr_pins.pulse(0, 5 + tm, 2);
      rd(lo, v);
      `CHK(v, 8'h02)
    end
    $display("test gate done");
  endtask

  // Timer 0 split counts its pin; Timer 1 under code 11 holds although it runs.
  task automatic t_split();
    wr(`TMR_ADDR_MODE, 8'h77);
    wr(`TMR_ADDR_T0_LO, 8'h00);
    wr(`TMR_ADDR_T1_LO, 8'h00);
    wr(`TMR_ADDR_T0_HI, 8'h00);
    wr(`TMR_ADDR_CTRL, 8'h50);
    u_tmr_pins.pulse(0, 5, 3);
    u_tmr_pins.pulse(0, 6, 2);
    rd(`TMR_ADDR_T0_LO, v);
    `CHK(v, 8'h03)
    rd(`TMR_ADDR_T1_LO, v);
    `CHK(v, 8'h00)
    // The upper half runs on the slow tick for about sixty cycles; phase gives slack.
    rd(`TMR_ADDR_T0_HI, v);
    `CHK((v >= 8'h03 && v <= 8'h07), 1'b1)
    $display("test split done");
  endtask

  // Ten ticks to overflow; the prescaler phase allows one tick of slack either way.
  task automatic t_presc();
    int n;
    int div;
    logic ok;
    for (int tm = 0; tm < 2; tm++) begin
      for (int fast = 0; fast < 2; fast++) begin
        div = (fast == 1) ? `TMR_DIV_FAST : `TMR_DIV_SLOW;
        wr(`TMR_ADDR_CTRL, 8'h00);
        wr(`TMR_ADDR_MODE, 8'h01 << (4 * tm));
        wr(`TMR_ADDR_CKDIV, (fast == 1) ? (8'h08 << tm) : 8'h00);
        wr((tm == 0) ? `TMR_ADDR_T0_HI : `TMR_ADDR_T1_HI, 8'hFF);
        wr((tm == 0) ? `TMR_ADDR_T0_LO : `TMR_ADDR_T1_LO, 8'hF6);
        wr(`TMR_ADDR_CTRL, 8'h10 << (2 * tm));
        n = 0;
        while (n < 200 && ((tm == 0) ? flag0 : flag1) !== 1'b1) begin
          @(negedge clock_i);
          n++;
        end
        ok = (n >= 9 * div) && (n <= 11 * div + 4);
        `CHK(ok, 1'b1)
      end
    end
    // Timer 1 is far from its next wrap, so only the acknowledge can move its flag.
    `CHK(flag1, 1'b1)
    @(negedge clock_i);
    ack1 = 1'b1;
    @(negedge clock_i);
    ack1 = 1'b0;
    `CHK(flag1, 1'b0)
    $display("test prescale done");
  endtask

  task automatic t_timer2();
    t2_count = 0;
    u_tmr_pins.pulse(1, 0, 3);
    `CHK(t2_count, 3)
    $display("test timer2 done");
  endtask

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // A hang is cut short well inside the run's cycle budget.
  initial begin
    repeat (50000) @(posedge clock_i);
    errors++;
    test_done();
  end

  initial begin
    errors       = 0;
    total_checks = 0;
    t2_count     = 0;
    rst_i        = 1'b1;
    sfr_addr_i   = 8'h00;
    sfr_wdata_i  = 8'h00;
    sfr_wr_i     = 1'b0;
    sfr_rd_i     = 1'b0;
    ack0         = 1'b0;
    ack1         = 1'b0;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_count16();
    t_count13();
    t_reload();
    t_gate();
    t_split();
    t_presc();
    t_timer2();
    test_done();
  end
endmodule
`default_nettype wire

// ===== sim/tmr_pins.sv
`default_nettype none
module tmr_pins (
  input  wire logic  clock_i,
  output logic [7:0] port0_o,
  output logic [3:0] port1_o,
  output logic       irq0_n_o,
  output logic       irq1_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Port pins rest high on their pull-ups; gate pins start permissive.
  initial begin
    port0_o  = 8'hFF;
    port1_o  = 4'hF;
    irq0_n_o = 1'b1;
    irq1_n_o = 1'b1;
  end

  // Each event holds low and high for four cycles, twice the synchroniser's need.
  task automatic pulse(input int port, input int idx, input int n);
    repeat (n) begin
      @(negedge clock_i);
      if (port == 0) port0_o[idx] = 1'b0;
      else port1_o[idx] = 1'b0;
      repeat (4) @(negedge clock_i);
      if (port == 0) port0_o[idx] = 1'b1;
      else port1_o[idx] = 1'b1;
      repeat (3) @(negedge clock_i);
    end
    // Let the last event pass the synchroniser before anyone reads the count.
    repeat (6) @(negedge clock_i);
  endtask

  // Gate levels change just after a falling clock edge.
  task automatic gate(input logic g0, input logic g1);
    @(negedge clock_i);
    irq0_n_o = g0;
    irq1_n_o = g1;
  endtask
endmodule
`default_nettype wire
